// file: verification/ahb_host.sv
/*
 Host model: single-word AHB-Lite transfers for the register bank.
 Assumes one slave whose hreadyout is looped back as hready.
*/
module ahb_host (
   // Clock
   input wire logic hclk,
   // Request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   // Answer
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // ============================================================
   // One transfer, bounded waits, released lines inverted
   task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output bit to);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~{22'h0, idx, 2'h0};
      hwdata <= wd;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 128);
      rd = hrdata;
      hwdata <= ~wd;
      to = (n >= 64);
   endtask : xfer
endmodule : ahb_host

// file: verification/analyzer_regs_tb.sv
/*
 Self-checking bench of the analyzer register bank.
 Assumes the host model and a short stability count.
*/
module analyzer_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STAB = 20;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rtc_set_stb;
   logic [1:0] htrans;
   logic [2:0] hsize, rtc_set_sel;
   logic [31:0] haddr, hwdata, hrdata, rd, wd;
   logic [15:0] display_gas, status, ex;
   logic [7:0] rtc_set_val;
   logic [47:0] r;
   logic [15:0] w [5];
   logic [7:0] idx [5] = '{analyzer_regs_pkg::IDX_SETTINGS,
      analyzer_regs_pkg::IDX_DISPLAY, analyzer_regs_pkg::IDX_UNITS,
      analyzer_regs_pkg::IDX_CALTAB, analyzer_regs_pkg::IDX_ALARM_CFG};
   analyzer_regs_pkg::meas_t meas, m;
   analyzer_regs_pkg::rtc_t rtc;
   analyzer_regs_pkg::cfg_t cfg;
   int errors, n_checks, seed;

   analyzer_regs #(.STABLE_CYCLES(STAB)) DUT (.hclk, .hresetn, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .meas, .rtc, .cfg, .display_gas,
      .status, .rtc_set_stb, .rtc_set_sel, .rtc_set_val);
   ahb_host host (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata);

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // ============================================================
   // Helpers
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [63:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      bit to;
      host.xfer(wr, a, d, rd, to);
      if (to) begin
         errors++;
         $display("[FAIL] %0t bus hang", $time);
         end_of_test();
      end
   endtask : bus
   function automatic logic [15:0] near(input logic [15:0] b, input int s);
      return b + 16'($random(seed) % s);
   endfunction : near
   function automatic logic [15:0] clampv(input logic [15:0] g,
      input logic en);
      if (en && g < 16'h4E20) return 16'h4E20;
      if (en && g > 16'h7530) return 16'h7530;
      return g;
   endfunction : clampv
   function automatic logic [15:0] exp_st(input analyzer_regs_pkg::meas_t x,
      input logic [15:0] ac, ct);
      logic [15:0] s;
      logic [1:0] p, t;
      s = 16'h0000;
      p = ct[0] ? x.phase_ext : ct[2:1];
      if (p == 2'h3) p = 2'h0;
      s[0] = x.high_sensitivity_range;
      s[1] = x.gas < x.range_lo || x.gas > x.range_hi;
      for (int k = 0; k < 2; k++) begin
         t = ac[6 * k + 2 * p +: 2];
         if (t == 2'h1 && x.gas < 16'h4E20) s[2] = 1'b1;
         if (t == 2'h2 && x.gas > 16'h4E20) s[3] = 1'b1;
      end
      s[4] = x.ma_phase < 16'h4E40 || x.ma_phase > 16'h4EF6;
      s[5] = x.ma_ext < 16'h4E40 || x.ma_ext > 16'h4EF6;
      s[7] = x.cell_t < 16'h4C2C || x.cell_t > 16'h5140;
      s[9] = x.vcomp <= 16'h0001 || x.vcomp > 16'h1FFF;
      s[10] = {1'b0, x.board_t} > 17'h07FFF + 17'(x.cell_sp);
      s[11 + p] = 1'b1;
      s[14] = x.blind;
      return s;
   endfunction : exp_st
   // ============================================================
   // Main sequence
   initial begin
      errors = 0;
      n_checks = 0;
      seed = 32'h3E20;
      hresetn = 1'b0;
      meas = '0;
      rtc = '0;
      repeat (20) @(posedge hclk);
      #1;
      chk({status, display_gas, hrdata}, {32'h00404E20, 32'h0}, "rst");
      chk(cfg, 64'h0, "rst cfg");
      @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         for (int k = 0; k < 5; k++) begin
            w[k] = 16'($random(seed));
            bus(1'b1, idx[k], {16'($random(seed)), w[k]});
         end
         bus(1'b1, analyzer_regs_pkg::IDX_STATUS, 32'hFFFF);
         for (int k = 0; k < 5; k++) begin
            bus(1'b0, idx[k], 32'h0);
            chk(rd, {16'h0, w[k]}, "readback");
         end
         chk(cfg, {w[0][2:0], w[2][6:4], w[0][6], w[2][1:0], w[2][3:2],
            w[2][7], w[2][13:11], w[3][0], w[3][2:1], w[1], w[4][11:0]},
            "cfg");
         m.gas = near(16'h4E20, 700);
         m.range_lo = near(16'h4C00, 600);
         m.range_hi = near(16'h5000, 600);
         m.ma_phase = near(16'h4E40 + 16'(i % 2) * 16'hB6, 6);
         m.ma_ext = near(16'h4EF6 - 16'(i % 2) * 16'hB6, 6);
         m.cell_t = (i % 2) ? near(16'h5140, 4) : near(16'h4C2C, 4);
         m.cell_sp = 16'($random(seed)) & 16'h003F;
         m.board_t = near(16'h8020, 40);
         m.vcomp = (i % 2) ? near(16'h0001, 3) : near(16'h1FFF, 3);
         {m.phase_ext, m.high_sensitivity_range, m.blind} = 4'($random(seed));
         @(posedge hclk);
         meas <= m;
         repeat (2) @(posedge hclk);
         #1;
         ex = exp_st(m, w[4], w[3]);
         chk(status & 16'hFFBF, ex, "status");
         chk(display_gas, clampv(m.gas, w[0][5]), "display");
         bus(1'b0, analyzer_regs_pkg::IDX_STATUS, 32'h0);
         chk(rd & 32'hFFFFFFBF, {16'h0, ex}, "status rd");
         bus(1'b0, 8'h7F, 32'h0);
         chk({hresp, rd}, 33'h0, "unmapped");
      end
      // ============================================================
      // Cell stability flag
      m = '0;
      m.cell_sp = 16'h001E;
      m.cell_t = 16'h4F4C;
      @(posedge hclk);
      meas <= m;
      repeat (STAB / 2) @(posedge hclk);
      #1;
      chk(status[6], 1'b1, "early");
      repeat (STAB) @(posedge hclk);
      #1;
      chk(status[6], 1'b0, "stable");
      m.cell_t = 16'h4F4E;
      @(posedge hclk);
      meas <= m;
      repeat (2) @(posedge hclk);
      #1;
      chk(status[6], 1'b1, "rearm");
      // ============================================================
      // Clock words
      for (int j = 0; j < 5; j++) begin
         wd = $random(seed);
         bus(1'b1, analyzer_regs_pkg::IDX_SET_HRS + 8'(j), wd);
         #1;
         chk({rtc_set_stb, rtc_set_sel, rtc_set_val}, {1'b1, 3'(j), wd[7:0]},
            "set");
      end
      r = 48'({$random(seed), $random(seed)});
      @(posedge hclk);
      rtc <= r;
      for (int j = 0; j < 3; j++) begin
         bus(1'b0, analyzer_regs_pkg::IDX_RTC_HM + 8'(j), 32'h0);
         chk(rd, {16'h0, r[47 - 16 * j -: 16]}, "rtc rd");
      end
      end_of_test();
   end
endmodule : analyzer_regs_tb

// file: verilog/analyzer_regs.sv
/*
 Analyzer register bank: AHB-Lite slave, configuration fields, status flags.
 Assumes measurement inputs come from logic on hclk, in raw register codes.
*/
// Implementation choices: register access over AHB-Lite and the register offsets.
module analyzer_regs #(
   parameter longint STABLE_CYCLES = analyzer_regs_pkg::STABLE_CYC
) (
   // Bus clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Measurement side
   input wire analyzer_regs_pkg::meas_t meas,
   input wire analyzer_regs_pkg::rtc_t rtc,
   output analyzer_regs_pkg::cfg_t cfg,
   output logic [15:0] display_gas,
   output logic [15:0] status,
   output logic rtc_set_stb,
   output logic [2:0] rtc_set_sel,
   output logic [7:0] rtc_set_val
);
   if (STABLE_CYCLES < 1 ||
       STABLE_CYCLES >= (64'h1 << analyzer_regs_pkg::CNT_W)) begin : g_bad_cnt
      $error("STABLE_CYCLES does not fit the counter");
   end

   localparam logic [analyzer_regs_pkg::CNT_W-1:0] STABLE_N =
      analyzer_regs_pkg::CNT_W'(STABLE_CYCLES);

   analyzer_regs_pkg::state_t s_q;
   analyzer_regs_pkg::state_t s_d;

   // ============================================================
   // Measurement checks
   logic out_range;
   logic ph_err;
   logic ext_err;
   logic cell_err;
   logic tc_err;
   logic pcb_hot;
   logic in_band;
   logic [17:0] sp_raw;
   logic [16:0] pcb_lim;
   logic [1:0] phase;
   logic [2:0] phase_oh;
   logic alm_lo;
   logic alm_hi;
   logic [1:0] atype;
   logic addr_ok;

   always_comb begin
      out_range = meas.gas < meas.range_lo ||
                  meas.gas > meas.range_hi;
      ph_err = meas.ma_phase < analyzer_regs_pkg::MA_MIN ||
               meas.ma_phase > analyzer_regs_pkg::MA_MAX;
      ext_err = meas.ma_ext < analyzer_regs_pkg::MA_MIN ||
                meas.ma_ext > analyzer_regs_pkg::MA_MAX;
      cell_err = meas.cell_t < analyzer_regs_pkg::CELL_MIN ||
                 meas.cell_t > analyzer_regs_pkg::CELL_MAX;
      tc_err = meas.vcomp <= analyzer_regs_pkg::TC_MIN ||
               meas.vcomp > analyzer_regs_pkg::TC_MAX;
      // Signed integer board temp against integer setpoint
      pcb_lim = {1'b0, analyzer_regs_pkg::OFS_INT} +
                {1'b0, meas.cell_sp};
      pcb_hot = {1'b0, meas.board_t} > pcb_lim;
      // Setpoint in one-decimal raw form
      sp_raw = analyzer_regs_pkg::OFS_DEC +
               18'(meas.cell_sp * 18'd10);
      in_band = {2'b00, meas.cell_t} + analyzer_regs_pkg::CELL_TOL
                   >= sp_raw &&
                {2'b00, meas.cell_t} <= sp_raw +
                   analyzer_regs_pkg::CELL_TOL;
      // Active phase from selected source
      if (s_q.caltab[analyzer_regs_pkg::B_PHASE_EXT]) begin
         phase = meas.phase_ext;
      end else begin
         phase = s_q.caltab[2:1];
      end
      if (phase == 2'd3) begin
         phase = 2'd0;
      end
      phase_oh = 3'(3'b001 << phase);
      alm_lo = 1'b0;
      alm_hi = 1'b0;
      for (int k = 0; k < 2; k++) begin
         atype = s_q.alarm_cfg[(k * 6 + 2 * phase) +: 2];
         if (atype == analyzer_regs_pkg::ALM_LOW &&
             meas.gas < s_q.alarm_sp[k]) begin
            alm_lo = 1'b1;
         end
         if (atype == analyzer_regs_pkg::ALM_HIGH &&
             meas.gas > s_q.alarm_sp[k]) begin
            alm_hi = 1'b1;
         end
      end
   end

   // ============================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.rtc_stb = 1'b0;
      // Address phase: latch index, fetch read word
      addr_ok = hsel && hready && htrans[1];
      s_d.wr = addr_ok && hwrite;
      if (addr_ok) begin
         s_d.idx = haddr[9:2];
         s_d.rdata = 32'h0000_0000;
         case (haddr[9:2])
            analyzer_regs_pkg::IDX_SETTINGS:
               s_d.rdata[15:0] = s_q.settings;
            analyzer_regs_pkg::IDX_DISPLAY:
               s_d.rdata[15:0] = s_q.display;
            analyzer_regs_pkg::IDX_UNITS:
               s_d.rdata[15:0] = s_q.units;
            analyzer_regs_pkg::IDX_CALTAB:
               s_d.rdata[15:0] = s_q.caltab;
            analyzer_regs_pkg::IDX_ALARM_CFG:
               s_d.rdata[15:0] = s_q.alarm_cfg;
            analyzer_regs_pkg::IDX_ALARM_SP1:
               s_d.rdata[15:0] = s_q.alarm_sp[0];
            analyzer_regs_pkg::IDX_ALARM_SP2:
               s_d.rdata[15:0] = s_q.alarm_sp[1];
            analyzer_regs_pkg::IDX_STATUS:
               s_d.rdata[15:0] = s_q.status;
            analyzer_regs_pkg::IDX_RTC_HM:
               s_d.rdata[15:0] = {rtc.hrs, rtc.min};
            analyzer_regs_pkg::IDX_RTC_SD:
               s_d.rdata[15:0] = {rtc.sec, rtc.day};
            analyzer_regs_pkg::IDX_RTC_MY:
               s_d.rdata[15:0] = {rtc.month, rtc.year};
            default:
               s_d.rdata = 32'h0000_0000;
         endcase
      end
      // Data phase: commit write, full 16-bit register values, low byte for clock sets
      if (s_q.wr) begin
         case (s_q.idx)
            analyzer_regs_pkg::IDX_SETTINGS:
               s_d.settings = hwdata[15:0];
            analyzer_regs_pkg::IDX_DISPLAY:
               s_d.display = hwdata[15:0];
            analyzer_regs_pkg::IDX_UNITS:
               s_d.units = hwdata[15:0];
            analyzer_regs_pkg::IDX_CALTAB:
               s_d.caltab = hwdata[15:0];
            analyzer_regs_pkg::IDX_ALARM_CFG:
               s_d.alarm_cfg = hwdata[15:0];
            analyzer_regs_pkg::IDX_ALARM_SP1:
               s_d.alarm_sp[0] = hwdata[15:0];
            analyzer_regs_pkg::IDX_ALARM_SP2:
               s_d.alarm_sp[1] = hwdata[15:0];
            default: begin
               if (s_q.idx >= analyzer_regs_pkg::IDX_SET_HRS &&
                   s_q.idx <= analyzer_regs_pkg::IDX_SET_YEAR) begin
                  s_d.rtc_stb = 1'b1;
                  s_d.rtc_sel = 3'(s_q.idx -
                                   analyzer_regs_pkg::IDX_SET_HRS);
                  s_d.rtc_val = hwdata[7:0];
               end
            end
         endcase
      end
      // Stability timer restarts whenever the cell leaves the band
      if (!in_band) begin
         s_d.stable_cnt = '0;
      end else if (s_q.stable_cnt < STABLE_N) begin
         s_d.stable_cnt = s_q.stable_cnt + 1'b1;
      end
      // Status rebuilt every cycle, never written by the host
      s_d.status = 16'h0000;
      s_d.status[analyzer_regs_pkg::S_HSR] = meas.high_sensitivity_range;
      s_d.status[analyzer_regs_pkg::S_RANGE] = out_range;
      s_d.status[analyzer_regs_pkg::S_ALM_LO] = alm_lo;
      s_d.status[analyzer_regs_pkg::S_ALM_HI] = alm_hi;
      s_d.status[analyzer_regs_pkg::S_PH_ERR] = ph_err;
      s_d.status[analyzer_regs_pkg::S_EXT_ERR] = ext_err;
      s_d.status[analyzer_regs_pkg::S_UNSTABLE] =
         !in_band || s_q.stable_cnt < STABLE_N;
      s_d.status[analyzer_regs_pkg::S_CELL_ERR] = cell_err;
      s_d.status[analyzer_regs_pkg::S_TC_ERR] = tc_err;
      s_d.status[analyzer_regs_pkg::S_PCB_HOT] = pcb_hot;
      s_d.status[analyzer_regs_pkg::S_PHASE0 +: 3] = phase_oh;
      s_d.status[analyzer_regs_pkg::S_BLIND] = meas.blind;
      // Displayed reading, clamped to 0..100 percent when enabled
      s_d.disp_gas = meas.gas;
      if (s_q.settings[analyzer_regs_pkg::B_CLAMP]) begin
         if (meas.gas < analyzer_regs_pkg::GAS_0PCT) begin
            s_d.disp_gas = analyzer_regs_pkg::GAS_0PCT;
         end else if (meas.gas > analyzer_regs_pkg::GAS_100PCT) begin
            s_d.disp_gas = analyzer_regs_pkg::GAS_100PCT;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.settings <= analyzer_regs_pkg::RST_SETTINGS;
         s_q.display <= analyzer_regs_pkg::RST_DISPLAY;
         s_q.units <= analyzer_regs_pkg::RST_UNITS;
         s_q.caltab <= analyzer_regs_pkg::RST_CALTAB;
         s_q.alarm_cfg <= analyzer_regs_pkg::RST_ALARM_CFG;
         s_q.alarm_sp <= {2{analyzer_regs_pkg::RST_ALARM_SP}};
         s_q.status <= analyzer_regs_pkg::RST_STATUS;
         s_q.disp_gas <= analyzer_regs_pkg::GAS_0PCT;
      end else begin
         s_q <= s_d;
      end
   end

   // ============================================================
   // Outputs
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign display_gas = s_q.disp_gas;
   assign status = s_q.status;
   assign rtc_set_stb = s_q.rtc_stb;
   assign rtc_set_sel = s_q.rtc_sel;
   assign rtc_set_val = s_q.rtc_val;
   assign cfg.field_cal_en = s_q.settings[2:0];
   assign cfg.fault_level_high =
      s_q.settings[analyzer_regs_pkg::B_FAULT_HI];
   assign cfg.temp_unit = s_q.units[1:0];
   assign cfg.press_unit = s_q.units[3:2];
   assign cfg.field_cal_two_gas = s_q.units[6:4];
   assign cfg.date_mdy = s_q.units[analyzer_regs_pkg::B_DATE_MDY];
   assign cfg.ext_quantity = s_q.units[13:11];
   assign cfg.phase_src_ext = s_q.caltab[0];
   assign cfg.cal_table = s_q.caltab[2:1];
   assign cfg.brightness = s_q.display[15:8];
   assign cfg.contrast = s_q.display[7:0];
   assign cfg.alarm_types = s_q.alarm_cfg[11:0];

   // ============================================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Status still shows its reset value one edge after release
   a_range_flag: assert property (
      $past(hresetn) |-> status[1] == $past(out_range))
      else $error("range flag does not follow gas reading");
   a_phase_current: assert property (
      $past(hresetn) && $past(meas.ma_phase) < analyzer_regs_pkg::MA_MIN
         |-> status[4])
      else $error("phase current low not flagged");
   a_ext_current: assert property (
      $past(hresetn) && $past(meas.ma_ext) > analyzer_regs_pkg::MA_MAX
         |-> status[5])
      else $error("sensor current high not flagged");
   a_unstable_hold: assert property (
      !in_band |=> status[6] ##1 (s_q.stable_cnt <= 1))
      else $error("cell stability flag cleared early");
   a_cell_fault: assert property (
      $past(hresetn) |->
         status[7] == $past(meas.cell_t > analyzer_regs_pkg::CELL_MAX ||
                            meas.cell_t < analyzer_regs_pkg::CELL_MIN))
      else $error("cell sensor fault mismatch");
   a_tc_fault: assert property (
      $past(hresetn) && $past(meas.vcomp) == 16'h0001 |-> status[9])
      else $error("conductivity fault not flagged");
   a_board_hot: assert property (
      $past(hresetn) |-> status[10] == $past(pcb_hot))
      else $error("board temperature flag mismatch");
   a_status_ro: assert property (
      s_q.wr && s_q.idx == analyzer_regs_pkg::IDX_STATUS
         |=> status[15] == 1'b0 && status[8] == 1'b0 &&
             status[analyzer_regs_pkg::S_TC_ERR] == $past(tc_err))
      else $error("host write reached status");
   a_clamp_span: assert property (
      $past(s_q.settings[5]) |-> display_gas >= 16'h4E20 &&
                                 display_gas <= 16'h7530)
      else $error("displayed gas outside clamp span");
   a_rtc_low_byte: assert property (
      s_q.wr && s_q.idx == analyzer_regs_pkg::IDX_SET_HRS
         |=> rtc_set_stb && rtc_set_sel == 3'h0 &&
             rtc_set_val == $past(hwdata[7:0]) ##1 !rtc_set_stb)
      else $error("clock set strobe wrong");
   a_phase_onehot: assert property (
      $past(hresetn) |-> $onehot(status[13:11]))
      else $error("active phase not one-hot");

   c_write_read: cover property (
      addr_ok && hwrite ##[1:4] addr_ok && !hwrite);
   c_rtc_set: cover property (rtc_set_stb);
   c_alarm_high: cover property (status[3]);
endmodule : analyzer_regs

// file: verilog/analyzer_regs_pkg.sv
/*
 Constants, register indices and carrier types of the analyzer register bank.
 Assumes a 200 MHz bus clock and measurement codes in the raw register form.
*/
// Function
// - Plain unsigned registers are full 16-bit values 0 to 65535, unscaled.
// - Settings bits 0 to 2 enable field calibration for phases one to three.
// - Settings bit 5 clamps the displayed gas reading to 0..100 percent.
// - Settings bit 6 selects fault output level: 0 low, 1 high.
// - Units bits 3:2 pick pressure unit: psia, bar absolute, kilopascal.
// - Units bits 4 to 6 pick per-phase calibration: offset or two-gas.
// - Units bit 7 picks date order: 0 day first, 1 month first.
// - Units bits 13:11 name the external sensor quantity; 15:14 spare.
// - Table register bit 0 picks phase source: internal or current loop.
// - Table register bits 2:1 pick calibration table one, two or three.
// - One-decimal values are raw minus 20000, divided by ten.
// - Two-decimal values are raw 0..40000, minus 20000, over one hundred.
// - Signed integers are raw minus 32767.
// - Clock words read two bytes; writes use only the low byte.
// - Status bit 1 marks gas reading outside calibrated range.
// - Status bit 4 marks phase current below 3.2 or above 21.4 mA.
// - Status bit 5 marks sensor current outside 3.2 to 21.4 mA.
// - Status bit 6 stays set until cell stable 0.1 degrees for 15 min.
// - Status bit 7 marks cell temperature below -50 or above 80 degrees.
// - Status bit 9 marks conductivity reading at most 1 or above 8191.
// - Status bit 10 marks board temperature above cell setpoint.
// - Alarm register holds six 2-bit types: off, low, high.
package analyzer_regs_pkg;
   // ============================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_SETTINGS = 8'h01;
   localparam logic [7:0] IDX_DISPLAY = 8'h02;
   localparam logic [7:0] IDX_UNITS = 8'h03;
   localparam logic [7:0] IDX_CALTAB = 8'h31;
   localparam logic [7:0] IDX_ALARM_CFG = 8'h43;
   localparam logic [7:0] IDX_SET_HRS = 8'h52;
   localparam logic [7:0] IDX_SET_YEAR = 8'h56;
   localparam logic [7:0] IDX_STATUS = 8'h5C;
   localparam logic [7:0] IDX_RTC_HM = 8'h5D;
   localparam logic [7:0] IDX_RTC_SD = 8'h5E;
   localparam logic [7:0] IDX_RTC_MY = 8'h5F;
   localparam logic [7:0] IDX_ALARM_SP1 = 8'h64;
   localparam logic [7:0] IDX_ALARM_SP2 = 8'h65;
   // ============================================================
   // Reset values
   localparam logic [15:0] RST_SETTINGS = 16'h0000;
   localparam logic [15:0] RST_DISPLAY = 16'h0000;
   localparam logic [15:0] RST_UNITS = 16'h0000;
   localparam logic [15:0] RST_CALTAB = 16'h0000;
   localparam logic [15:0] RST_ALARM_CFG = 16'h0000;
   localparam logic [15:0] RST_ALARM_SP = 16'h4E20;
   localparam logic [15:0] RST_STATUS = 16'h0040;
   // ============================================================
   // Field positions
   localparam int B_CLAMP = 5;
   localparam int B_FAULT_HI = 6;
   localparam int B_PHASE_EXT = 0;
   localparam int B_DATE_MDY = 7;
   localparam int S_HSR = 0;
   localparam int S_RANGE = 1;
   localparam int S_ALM_LO = 2;
   localparam int S_ALM_HI = 3;
   localparam int S_PH_ERR = 4;
   localparam int S_EXT_ERR = 5;
   localparam int S_UNSTABLE = 6;
   localparam int S_CELL_ERR = 7;
   localparam int S_TC_ERR = 9;
   localparam int S_PCB_HOT = 10;
   localparam int S_PHASE0 = 11;
   localparam int S_BLIND = 14;
   localparam logic [1:0] ALM_LOW = 2'h1;
   localparam logic [1:0] ALM_HIGH = 2'h2;
   // ============================================================
   // Encoding offsets and limits in raw codes
   localparam logic [17:0] OFS_DEC = 18'h04E20;
   localparam logic [15:0] OFS_INT = 16'h7FFF;
   localparam logic [15:0] GAS_0PCT = 16'h4E20;
   localparam logic [15:0] GAS_100PCT = 16'h7530;
   localparam logic [15:0] MA_MIN = 16'h4E40;
   localparam logic [15:0] MA_MAX = 16'h4EF6;
   localparam logic [15:0] CELL_MIN = 16'h4C2C;
   localparam logic [15:0] CELL_MAX = 16'h5140;
   localparam logic [17:0] CELL_TOL = 18'h00001;
   localparam logic [15:0] TC_MIN = 16'h0001;
   localparam logic [15:0] TC_MAX = 16'h1FFF;
   // ============================================================
   // Timing
   localparam longint STABLE_MIN = 15;
   localparam longint CLK_HZ = 200000000;
   localparam longint STABLE_CYC = STABLE_MIN * 60 * CLK_HZ;
   localparam int CNT_W = 40;

   typedef struct packed {
      logic [15:0] gas;
      logic [15:0] range_lo;
      logic [15:0] range_hi;
      logic [15:0] ma_phase;
      logic [15:0] ma_ext;
      logic [15:0] cell_t;
      logic [15:0] cell_sp;
      logic [15:0] board_t;
      logic [15:0] vcomp;
      logic [1:0] phase_ext;
      logic high_sensitivity_range;
      logic blind;
   } meas_t;

   typedef struct packed {
      logic [7:0] hrs;
      logic [7:0] min;
      logic [7:0] sec;
      logic [7:0] day;
      logic [7:0] month;
      logic [7:0] year;
   } rtc_t;

   typedef struct packed {
      logic [2:0] field_cal_en;
      logic [2:0] field_cal_two_gas;
      logic fault_level_high;
      logic [1:0] temp_unit;
      logic [1:0] press_unit;
      logic date_mdy;
      logic [2:0] ext_quantity;
      logic phase_src_ext;
      logic [1:0] cal_table;
      logic [7:0] brightness;
      logic [7:0] contrast;
      logic [11:0] alarm_types;
   } cfg_t;

   typedef struct packed {
      logic [7:0] idx;
      logic wr;
      logic [15:0] settings;
      logic [15:0] display;
      logic [15:0] units;
      logic [15:0] caltab;
      logic [15:0] alarm_cfg;
      logic [1:0][15:0] alarm_sp;
      logic [15:0] status;
      logic [CNT_W-1:0] stable_cnt;
      logic [15:0] disp_gas;
      logic [31:0] rdata;
      logic [2:0] rtc_sel;
      logic [7:0] rtc_val;
      logic rtc_stb;
   } state_t;
endpackage : analyzer_regs_pkg
